/* hw/sdp_regs.sv */
// Program word decoder with AXI4-Lite slave and power control
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module sdp_regs (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address, data and response
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Chip enable pin
    input  wire logic        chip_enable,
    // Decoded settings
    output logic [10:0]      rf_main_count,
    output logic [11:0]      rf_frac_numerator,
    output logic [11:0]      rf_frac_denominator,
    output logic [5:0]       rf_reference_divider,
    output logic             rf_prescaler_select,
    output logic [18:0]      if_main_count,
    output logic [12:0]      rf_total_divide,
    output logic             rf_loop_on,
    output logic             rf_cp_tristate,
    output logic             if_loop_on
);
    // ==========================================================
    // Chip enable synchroniser
    logic ce_m_q, ce_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ce_m_q <= 1'b0;
            ce_q   <= 1'b0;
        end else begin
            ce_m_q <= chip_enable;
            ce_q   <= ce_m_q;
        end
    end

    // ==========================================================
    // Write channel
    sdp_pkg::sdp_wr_t wst_q, wst_d;
    logic [7:0]  awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic        have_aw_q, have_aw_d, have_w_q, have_w_d;
    logic [1:0]  bresp_q, bresp_d;
    logic        wr_fire;
    logic [3:0]  wsel;

    assign s_axi_awready = (wst_q != sdp_pkg::ST_RESP) && !have_aw_q;
    assign s_axi_wready  = (wst_q != sdp_pkg::ST_RESP) && !have_w_q;
    assign s_axi_bvalid  = (wst_q == sdp_pkg::ST_RESP);
    assign s_axi_bresp   = bresp_q;

    // Collects address and data in either order, then answers
    always_comb begin
        wst_d     = wst_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        have_aw_d = have_aw_q;
        have_w_d  = have_w_q;
        bresp_d   = bresp_q;
        wr_fire   = 1'b0;
        unique case (wst_q)
            sdp_pkg::ST_IDLE, sdp_pkg::ST_WAIT: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    awaddr_d  = s_axi_awaddr;
                    have_aw_d = 1'b1;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    wdata_d  = s_axi_wdata;
                    have_w_d = 1'b1;
                end
                wst_d = (have_aw_d || have_w_d) ? sdp_pkg::ST_WAIT : sdp_pkg::ST_IDLE;
                if (have_aw_d && have_w_d) begin
                    wr_fire   = 1'b1;
                    have_aw_d = 1'b0;
                    have_w_d  = 1'b0;
                    wst_d     = sdp_pkg::ST_RESP;
                    bresp_d   = (awaddr_d == sdp_pkg::ADDR_WORD || awaddr_d == sdp_pkg::ADDR_CTRL)
                              ? sdp_pkg::RESP_OKAY : sdp_pkg::RESP_SLVERR;
                end
            end
            sdp_pkg::ST_RESP: begin
                if (s_axi_bready) begin
                    wst_d = sdp_pkg::ST_IDLE;
                end
            end
            default: wst_d = sdp_pkg::ST_IDLE;
        endcase
    end

    // Write channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_q     <= sdp_pkg::ST_IDLE;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h00000000;
            have_aw_q <= 1'b0;
            have_w_q  <= 1'b0;
            bresp_q   <= sdp_pkg::RESP_OKAY;
        end else begin
            wst_q     <= wst_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            have_aw_q <= have_aw_d;
            have_w_q  <= have_w_d;
            bresp_q   <= bresp_d;
        end
    end

    // ==========================================================
    // Word decode into setting registers
    logic [23:0] rfmain_q, rfmain_d, rfref_q, rfref_d, ifmain_q, ifmain_d;
    logic        auto_power_up_q, auto_power_up_d;
    logic        word_wr, main_wr;

    assign wsel    = wdata_d[3:0];
    assign word_wr = wr_fire && (awaddr_d == sdp_pkg::ADDR_WORD) && (&s_axi_wstrb[2:0] || have_w_q);
    assign main_wr = word_wr && !wsel[0];

    // Routes each latched word by its control bits
    always_comb begin
        rfmain_d = rfmain_q;
        rfref_d  = rfref_q;
        ifmain_d = ifmain_q;
        auto_power_up_d   = auto_power_up_q;
        if (main_wr) begin
            rfmain_d = wdata_d[23:0];
            if (auto_power_up_q) begin
                ifmain_d[sdp_pkg::PD_BIT] = 1'b0;
            end
        end else if (word_wr && wsel == sdp_pkg::SEL_RFREF) begin
            rfref_d = wdata_d[23:0];
        end else if (word_wr && wsel == sdp_pkg::SEL_IFMAIN) begin
            ifmain_d = wdata_d[23:0];
        end
        if (wr_fire && awaddr_d == sdp_pkg::ADDR_CTRL) begin
            auto_power_up_d = wdata_d[sdp_pkg::CTRL_AUTO_POWER_UP_BIT];
        end
    end

    // Setting registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rfmain_q <= sdp_pkg::RST_WORD;
            rfref_q  <= {2'b00, sdp_pkg::RST_R, 16'h0000};
            ifmain_q <= sdp_pkg::RST_WORD;
            auto_power_up_q   <= 1'b0;
        end else begin
            rfmain_q <= rfmain_d;
            rfref_q  <= rfref_d;
            ifmain_q <= ifmain_d;
            auto_power_up_q   <= auto_power_up_d;
        end
    end

    // ==========================================================
    // Field outputs and power control
    logic [5:0] upper;
    logic [2:0] middle;
    logic [1:0] low;

    assign rf_main_count        = rfmain_q[sdp_pkg::N_MSB:sdp_pkg::N_LSB];
    assign rf_frac_numerator    = rfmain_q[sdp_pkg::FN_MSB:sdp_pkg::FN_LSB];
    assign rf_frac_denominator  = rfref_q[sdp_pkg::FD_MSB:sdp_pkg::FD_LSB];
    assign rf_reference_divider = rfref_q[sdp_pkg::R_MSB:sdp_pkg::R_LSB];
    assign rf_prescaler_select  = rfref_q[sdp_pkg::PSEL_BIT];
    assign if_main_count        = ifmain_q[sdp_pkg::IFN_MSB:sdp_pkg::IFN_LSB];

    sdp_divsplit u_split (
        .count  (rf_main_count),
        .psel   (rf_prescaler_select),
        .upper  (upper),
        .middle (middle),
        .low    (low),
        .total  (rf_total_divide)
    );

    // RF power priority: chip enable, then auto power-up, then bit; IF power: chip enable, then bit
    assign rf_loop_on     = ce_q && (auto_power_up_q || !rfref_q[sdp_pkg::PD_BIT]);
    assign rf_cp_tristate = !rf_loop_on;
    assign if_loop_on     = ce_q && !ifmain_q[sdp_pkg::PD_BIT];

    // ==========================================================
    // Read channel
    logic        rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  rresp_q, rresp_d;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // Read decode, answer one cycle after address taken
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d  = sdp_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                sdp_pkg::ADDR_STATUS: rdata_d = {29'h00000000, ce_q, if_loop_on, rf_loop_on};
                sdp_pkg::ADDR_CTRL:   rdata_d = {31'h00000000, auto_power_up_q};
                sdp_pkg::ADDR_RFMAIN: rdata_d = {8'h00, rfmain_q};
                sdp_pkg::ADDR_RFREF:  rdata_d = {8'h00, rfref_q};
                sdp_pkg::ADDR_IFMAIN: rdata_d = {8'h00, ifmain_q};
                sdp_pkg::ADDR_SPLIT:  rdata_d = {8'h00, rf_total_divide, upper, middle, low};
                default: begin
                    rdata_d = 32'h00000000;
                    rresp_d = sdp_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // Read channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= sdp_pkg::RESP_OKAY;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

    // ==========================================================
    // Assertions
    property p_main_decode;
        @(posedge aclk) disable iff (!aresetn)
        main_wr |=> rf_main_count == $past(wdata_d[23:13]);
    endproperty
    a_main_decode: assert property (p_main_decode) else $error("main count not taken");

    property p_split;
        @(posedge aclk) disable iff (!aresetn)
        rf_total_divide == 13'((rf_prescaler_select ? 32 : 16) * rf_main_count[10:5]
                          + 4 * rf_main_count[4:2] + rf_main_count[1:0]);
    endproperty
    a_split: assert property (p_split) else $error("divide total wrong");

    property p_ref_decode;
        @(posedge aclk) disable iff (!aresetn)
        (word_wr && wsel == sdp_pkg::SEL_RFREF) |=> rf_reference_divider == $past(wdata_d[21:16])
            && rf_frac_denominator == $past(wdata_d[15:4]);
    endproperty
    a_ref_decode: assert property (p_ref_decode) else $error("reference word wrong");

    property p_ce_low;
        @(posedge aclk) disable iff (!aresetn)
        !ce_q |-> !rf_loop_on && !if_loop_on && rf_cp_tristate;
    endproperty
    a_ce_low: assert property (p_ce_low) else $error("chip enable low not obeyed");

    property p_auto_power_up_up;
        @(posedge aclk) disable iff (!aresetn)
        (ce_q && auto_power_up_q) |-> rf_loop_on;
    endproperty
    a_auto_power_up_up: assert property (p_auto_power_up_up) else $error("auto power-up ignored");

    property p_pd_bit;
        @(posedge aclk) disable iff (!aresetn)
        (ce_q && !auto_power_up_q) |-> rf_loop_on == !rfref_q[23];
    endproperty
    a_pd_bit: assert property (p_pd_bit) else $error("RF power bit ignored");

    property p_if_clear;
        @(posedge aclk) disable iff (!aresetn)
        (main_wr && auto_power_up_q) |=> !ifmain_q[23];
    endproperty
    a_if_clear: assert property (p_if_clear) else $error("IF power-down not cleared");

    property p_if_decode;
        @(posedge aclk) disable iff (!aresetn)
        (word_wr && wsel == sdp_pkg::SEL_IFMAIN) |=> if_main_count == $past(wdata_d[22:4]);
    endproperty
    a_if_decode: assert property (p_if_decode) else $error("IF word wrong");

    property p_route;
        @(posedge aclk) disable iff (!aresetn)
        (word_wr && wsel[0]) |=> $stable(rfmain_q);
    endproperty
    a_route: assert property (p_route) else $error("wrong word routed");

    c_main: cover property (@(posedge aclk) main_wr);
    c_ref:  cover property (@(posedge aclk) word_wr && wsel == sdp_pkg::SEL_RFREF);
    c_ifcl: cover property (@(posedge aclk) main_wr && auto_power_up_q && ifmain_q[23]);
endmodule

/* hw/sdp_pkg.sv */
// Package of constants for the synthesizer program word decoder
package sdp_pkg;
    // ==========================================================
    // Register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] ADDR_WORD   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CTRL   = 8'h08;
    localparam logic [7:0] ADDR_RFMAIN = 8'h0c;
    localparam logic [7:0] ADDR_RFREF  = 8'h10;
    localparam logic [7:0] ADDR_IFMAIN = 8'h14;
    localparam logic [7:0] ADDR_SPLIT  = 8'h18;
    // ==========================================================
    // Word layout
    localparam int WORD_W          = 24;
    localparam int N_MSB           = 23;
    localparam int N_LSB           = 13;
    localparam int FN_MSB          = 12;
    localparam int FN_LSB          = 1;
    localparam int PD_BIT          = 23;
    localparam int PSEL_BIT        = 22;
    localparam int R_MSB           = 21;
    localparam int R_LSB           = 16;
    localparam int FD_MSB          = 15;
    localparam int FD_LSB          = 4;
    localparam int IFN_MSB         = 22;
    localparam int IFN_LSB         = 4;
    localparam logic [3:0] SEL_RFREF  = 4'h3;
    localparam logic [3:0] SEL_IFMAIN = 4'h5;
    // ==========================================================
    // Divide fields and prescaler bases
    localparam logic [6:0] BASE_SMALL = 7'h10;
    localparam logic [6:0] BASE_LARGE = 7'h20;
    localparam logic [12:0] MID_WEIGHT = 13'h0004;
    // ==========================================================
    // Control bits and reset values
    localparam int CTRL_AUTO_POWER_UP_BIT      = 0;
    localparam logic [23:0] RST_WORD  = 24'h000000;
    localparam logic [5:0]  RST_R     = 6'h01;
    // ==========================================================
    // AXI answer codes and write channel states
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_RESP = 3'b100
    } sdp_wr_t;
endpackage

/* hw/sdp_divsplit.sv */
// Splits an RF main count into upper, middle and low fields
`timescale 1ns/10ps
module sdp_divsplit (
    // Count in
    input  wire logic [10:0] count,
    input  wire logic        psel,
    // Fields and total out
    output logic      [5:0]  upper,
    output logic      [2:0]  middle,
    output logic      [1:0]  low,
    output logic      [12:0] total
);
    // Field split and divide total
    always_comb begin
        upper  = count[10:5];
        middle = count[4:2];
        low    = count[1:0];
        total  = 13'(({6'h00, psel ? sdp_pkg::BASE_LARGE : sdp_pkg::BASE_SMALL}) * {7'h00, upper})
               + sdp_pkg::MID_WEIGHT * {10'h000, middle} + {11'h000, low};
    end
endmodule

/* sim/sdp_host.sv */
// Host model that issues AXI4-Lite writes and reads to the word decoder
`timescale 1ns/10ps
module sdp_host (
    // Clock
    input  wire logic        aclk,
    // Write channels
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    // Read channels
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    // ==========================================================
    // Bus idle at time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    // ==========================================================
    // Whole word in one write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask
    // Read, holding rready until the answer arrives
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask
endmodule

/* sim/tb.sv */
// Testbench for the synthesizer program word decoder
`timescale 1ns/10ps
module tb;
    logic aclk, aresetn, chip_enable, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [10:0] rf_main_count;
    logic [11:0] rf_frac_numerator, rf_frac_denominator;
    logic [5:0] rf_reference_divider;
    logic [18:0] if_main_count;
    logic [12:0] rf_total_divide, tot;
    logic rf_prescaler_select, rf_loop_on, rf_cp_tristate, if_loop_on, on;
    int mismatches, checks, cycles;
    // Legal field sets {psel, upper, middle, low}: 80, 1023, 231, 2039
    logic [11:0] tbl [4] = '{{1'b0, 6'd5, 3'd0, 2'd0}, {1'b0, 6'd63, 3'd3, 2'd3},
                             {1'b1, 6'd7, 3'd1, 2'd3}, {1'b1, 6'd63, 3'd5, 2'd3}};
    // ==========================================================
    // Design and host model
    sdp_regs DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .chip_enable, .rf_main_count, .rf_frac_numerator, .rf_frac_denominator,
        .rf_reference_divider, .rf_prescaler_select, .if_main_count, .rf_total_divide,
        .rf_loop_on, .rf_cp_tristate, .if_loop_on);
    sdp_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    // ==========================================================
    // Clock and hang guard
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    // ==========================================================
    // Compare, verdict and bus helpers
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic put(input logic [23:0] w);
        host.wr(sdp_pkg::ADDR_WORD, {8'h00, w}, r);
        chk("bresp", {30'h0, r}, {30'h0, sdp_pkg::RESP_OKAY});
        @(posedge aclk);
        #1;
    endtask
    task automatic get(input logic [7:0] a);
        host.rd(a, d, r);
        chk("rresp", {30'h0, r}, {30'h0, sdp_pkg::RESP_OKAY});
    endtask
    task automatic ctrl(input logic auto_power_up);
        host.wr(sdp_pkg::ADDR_CTRL, {31'h0, auto_power_up}, r);
        get(sdp_pkg::ADDR_CTRL);
        chk("ctrl", d, {31'h0, auto_power_up});
    endtask
    // ==========================================================
    // Test sequence
    initial begin
        aresetn = 1'b0;
        chip_enable = 1'b1;
        cycles = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        #1;
        chk("ref reset", {26'h0, rf_reference_divider}, 32'h01);
        chk("count reset", {21'h0, rf_main_count}, 32'h0);
        get(sdp_pkg::ADDR_STATUS);
        chk("status", d, 32'h7);
        ctrl(1'b0);
        $display("test reset done");
        // Main word with both prescaler bases
        for (int i = 0; i < 4; i++) begin
            put({1'b0, tbl[i][11], 6'd1, 12'h000, sdp_pkg::SEL_RFREF});
            put({tbl[i][10:0], 12'h5a0 + 12'(i), 1'b0});
            tot = (tbl[i][11] ? 13'd32 : 13'd16) * 13'(tbl[i][10:5]) + 13'd4 * tbl[i][4:2] + tbl[i][1:0];
            chk("count", {21'h0, rf_main_count}, {21'h0, tbl[i][10:0]});
            chk("numerator", {20'h0, rf_frac_numerator}, 32'h5a0 + i);
            chk("total", {19'h0, rf_total_divide}, {19'h0, tot});
            get(sdp_pkg::ADDR_SPLIT);
            chk("split", d, {8'h0, tot, tbl[i][10:0]});
        end
        $display("test main word done");
        // Reference word at the top of the divider range, loop powered down
        put({1'b1, 1'b1, 6'd63, 12'hfed, sdp_pkg::SEL_RFREF});
        chk("ref", {26'h0, rf_reference_divider}, 32'h3f);
        chk("denominator", {20'h0, rf_frac_denominator}, 32'hfed);
        get(sdp_pkg::ADDR_RFREF);
        chk("ref word", d, 32'h00fffed3);
        chk("psel", {31'h0, rf_prescaler_select}, 32'h1);
        chk("cp float", {31'h0, rf_cp_tristate}, 32'h1);
        put({1'b1, 19'h5a5a5, sdp_pkg::SEL_IFMAIN});
        chk("if count", {13'h0, if_main_count}, 32'h5a5a5);
        chk("if off", {31'h0, if_loop_on}, 32'h0);
        get(sdp_pkg::ADDR_IFMAIN);
        chk("if word", d, 32'h00da5a55);
        // Unselected word and unmapped place change nothing
        put(24'hfffff7);
        chk("ref kept", {26'h0, rf_reference_divider}, 32'h3f);
        chk("if kept", {13'h0, if_main_count}, 32'h5a5a5);
        chk("main kept", {21'h0, rf_main_count}, {21'h0, tbl[3][10:0]});
        host.wr(8'h1c, 32'hffffff, r);
        chk("bad wr", {30'h0, r}, {30'h0, sdp_pkg::RESP_SLVERR});
        host.rd(8'h1c, d, r);
        chk("bad rd", {30'h0, r}, {30'h0, sdp_pkg::RESP_SLVERR});
        chk("bad rd data", d, 32'h0);
        $display("test decode done");
        // Power precedence over every pin, setting and bit combination
        for (int k = 0; k < 8; k++) begin
            ctrl(k[1]);
            put({k[0], 1'b0, 6'd1, 12'h000, sdp_pkg::SEL_RFREF});
            @(posedge aclk);
            chip_enable <= k[2];
            repeat (3) @(posedge aclk);
            #1;
            on = k[2] & (k[1] | ~k[0]);
            chk("rf on", {31'h0, rf_loop_on}, {31'h0, on});
            chk("cp float", {31'h0, rf_cp_tristate}, {31'h0, ~on});
        end
        $display("test power done");
        // Auto power-up and main word clear IF power-down; pin low wins
        put({1'b1, 19'h00100, sdp_pkg::SEL_IFMAIN});
        chk("if off", {31'h0, if_loop_on}, 32'h0);
        put({11'h0a0, 12'h000, 1'b0});
        chk("if woken", {31'h0, if_loop_on}, 32'h1);
        get(sdp_pkg::ADDR_RFMAIN);
        chk("main word", d, 32'h00140000);
        @(posedge aclk);
        chip_enable <= 1'b0;
        repeat (3) @(posedge aclk);
        #1;
        chk("if pin off", {31'h0, if_loop_on}, 32'h0);
        @(posedge aclk);
        chip_enable <= 1'b1;
        ctrl(1'b0);
        put({1'b1, 19'h00100, sdp_pkg::SEL_IFMAIN});
        put({11'h0a0, 12'h000, 1'b0});
        chk("if stays off", {31'h0, if_loop_on}, 32'h0);
        $display("test if power done");
        tally_and_finish();
    end
endmodule
